// ---- logic/sss_pkg.sv ----
// Shared constants for the synchronous flow-through SRAM port
package sss_pkg;
  localparam int ADDR_W     = 17;
  localparam int DATA_W     = 36;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int DEPTH      = 1 << ADDR_W;
  localparam int FIFO_DEPTH = 16;
  localparam int BURST_LEN  = 4;
  localparam logic [1:0] BURST_MASK = 2'h3;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;

  // Pending data-phase kind, fixed at the load cycle
  typedef enum logic [1:0] {
    SSS_IDLE  = 2'b00,
    SSS_READ  = 2'b01,
    SSS_WRITE = 2'b11
  } sss_phase_t;
endpackage

// ---- logic/sss_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    wrPtr_d;
  logic [AW-1:0]    rdPtr_q;
  logic [AW-1:0]    rdPtr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  always_comb begin
    inReady  = (count_q != (AW+1)'(DEPTH));
    outValid = (count_q != '0);
    outData  = mem_q[rdPtr_q];
    push     = inValid && inReady;
    pop      = outValid && outReady;
    wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d  = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage needs no reset; empty flag guards stale entries
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// ---- logic/sss_sram_port.sv ----
// Synchronous flow-through SRAM port with suspend, select and burst control
// How it works
// - Write data taken on next unsuspended edge
// - Read word driven next cycle despite deselect
// - Write data accepted next cycle despite deselect
// - Data bus floats from reset until read
// - Selected only when both lows low, high high
// - Deselect on a load cycle blocks any new access and ends any burst
// - Undriven burst order reads as high
// - Suspend holds read word on bus
// - Direction ignored while bursting, fixed at load
`timescale 1ns/1ns
`default_nettype none
module sss_sram_port (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [sss_pkg::ADDR_W-1:0]  address,
  input  wire logic                        readNotWrite,
  input  wire logic                        advance_or_load,
  input  wire logic                        select_low_a_n,
  input  wire logic                        select_low_b_n,
  input  wire logic                        select_high,
  input  wire logic                        suspend_input,
  input  wire logic [sss_pkg::LANES-1:0]   byte_lane_write_n,
  input  wire logic                        outputGate_n,
  input  wire logic                        burst_order_select_n,
  input  wire logic                        burst_order_select_oe,
  input  wire logic [sss_pkg::DATA_W-1:0]  dataIn,
  output logic      [sss_pkg::DATA_W-1:0]  dataOut,
  output logic                             dataOe,
  output logic                             writeBusy,
  output logic                             writeStall
);
  localparam int AW = sss_pkg::ADDR_W;
  localparam int DW = sss_pkg::DATA_W;
  localparam int WW = AW + DW + sss_pkg::LANES;

  logic [DW-1:0]           mem_q [sss_pkg::DEPTH];
  sss_pkg::sss_phase_t     phase_q;
  sss_pkg::sss_phase_t     phase_d;
  logic [AW-1:0]           base_q;
  logic [AW-1:0]           base_d;
  logic [1:0]              beat_q;
  logic [1:0]              beat_d;
  logic [sss_pkg::LANES-1:0] lanes_q;
  logic [sss_pkg::LANES-1:0] lanes_d;
  logic                    bursting_q;
  logic                    bursting_d;
  logic [DW-1:0]           rdWord_q;
  logic [DW-1:0]           rdWord_d;
  logic                    rdValid_q;
  logic                    rdValid_d;
  logic                    enabled;
  logic                    selected;
  logic                    orderLinear;
  logic [AW-1:0]           beatAddr;
  logic [AW-1:0]           accessAddr;
  logic                    wrPush;
  logic                    wrReady;
  logic                    wrValid;
  logic [WW-1:0]           wrEntry;
  logic [WW-1:0]           wrHead;
  logic [AW-1:0]           headAddr;
  logic [DW-1:0]           headData;
  logic [sss_pkg::LANES-1:0] headLanes;

  // Edges with suspend high leave port state untouched; queued writes still commit to the array
  always_comb begin
    enabled = !suspend_input;
    selected = !select_low_a_n && !select_low_b_n && select_high;
    orderLinear = burst_order_select_oe ? !burst_order_select_n : 1'b0;
    if (orderLinear) begin
      beatAddr = {base_q[AW-1:2], base_q[1:0] + beat_q};
    end else begin
      beatAddr = {base_q[AW-1:2], base_q[1:0] ^ beat_q};
    end
  end

  always_comb begin
    phase_d    = phase_q;
    base_d     = base_q;
    beat_d     = beat_q;
    lanes_d    = lanes_q;
    bursting_d = bursting_q;
    if (enabled) begin
      if (!advance_or_load) begin
        if (selected) begin
          phase_d    = readNotWrite ? sss_pkg::SSS_READ : sss_pkg::SSS_WRITE;
          base_d     = address;
          beat_d     = 2'h0;
          lanes_d    = byte_lane_write_n;
          bursting_d = 1'b1;
        end else begin
          phase_d    = sss_pkg::SSS_IDLE;
          bursting_d = 1'b0;
        end
      end else if (bursting_q) begin
        beat_d  = (beat_q + 2'h1) & sss_pkg::BURST_MASK;
        lanes_d = byte_lane_write_n;
      end else begin
        phase_d = sss_pkg::SSS_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_q    <= sss_pkg::SSS_IDLE;
      base_q     <= '0;
      beat_q     <= 2'h0;
      lanes_q    <= '1;
      bursting_q <= 1'b0;
    end else begin
      phase_q    <= phase_d;
      base_q     <= base_d;
      beat_q     <= beat_d;
      lanes_q    <= lanes_d;
      bursting_q <= bursting_d;
    end
  end

  always_comb begin
    accessAddr = beatAddr;
    wrPush  = enabled && (phase_q == sss_pkg::SSS_WRITE);
    wrEntry = {accessAddr, dataIn, lanes_q};
    rdWord_d  = rdWord_q;
    rdValid_d = rdValid_q;
    if (enabled) begin
      rdValid_d = (phase_q == sss_pkg::SSS_READ);
      if (phase_q == sss_pkg::SSS_READ) begin
        rdWord_d = mem_q[accessAddr];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdWord_q  <= sss_pkg::DATA_RESET;
      rdValid_q <= 1'b0;
    end else begin
      rdWord_q  <= rdWord_d;
      rdValid_q <= rdValid_d;
    end
  end

  // Writes queue ahead of the array so a slow commit path never drops data
  sss_fifo #(
    .WIDTH (WW),
    .DEPTH (sss_pkg::FIFO_DEPTH)
  ) u_wrFifo (
    .core_clk (core_clk),
    .reset    (reset),
    .inValid  (wrPush),
    .inReady  (wrReady),
    .inData   (wrEntry),
    .outValid (wrValid),
    .outReady (1'b1),
    .outData  (wrHead)
  );

  always_comb begin
    headAddr  = wrHead[WW-1 -: AW];
    headData  = wrHead[sss_pkg::LANES +: DW];
    headLanes = wrHead[sss_pkg::LANES-1:0];
  end

  // Array commit; reads of a word still queued see the old value for one cycle
  for (genvar i = 0; i < sss_pkg::LANES; i++) begin : g_lane
    always_ff @(posedge core_clk) begin
      if (wrValid && !headLanes[i]) begin
        mem_q[headAddr][i*sss_pkg::LANE_W +: sss_pkg::LANE_W] <=
          headData[i*sss_pkg::LANE_W +: sss_pkg::LANE_W];
      end
    end
  end

  always_comb begin
    dataOut    = rdWord_q;
    dataOe     = rdValid_q && !outputGate_n;
    writeBusy  = wrValid;
    writeStall = !wrReady;
  end
endmodule
`default_nettype wire

// ---- testbench/sss_port_monitor.sv ----
// Pin-level assertions for the SRAM port
`timescale 1ns/1ns
`default_nettype none
module sss_port_monitor (
  input wire logic                       core_clk,
  input wire logic                       reset,
  input wire logic                       readNotWrite,
  input wire logic                       advance_or_load,
  input wire logic                       select_low_a_n,
  input wire logic                       select_low_b_n,
  input wire logic                       select_high,
  input wire logic                       suspend_input,
  input wire logic                       outputGate_n,
  input wire logic [sss_pkg::DATA_W-1:0] dataOut,
  input wire logic                       dataOe,
  input wire logic                       writeBusy
);
  logic sel;
  logic ld;
  assign sel = !select_low_a_n && !select_low_b_n && select_high;
  assign ld = !suspend_input && !advance_or_load;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Read word is registered on the enabled edge after the load edge
  chk_read_drives: assert property (ld && sel && readNotWrite ##1 !suspend_input
    |=> outputGate_n || dataOe)
    else $error("read word not driven");
  chk_deselect_idle: assert property (ld && !sel ##1 !suspend_input |=> !dataOe)
    else $error("deselected load drove bus");
  chk_write_floats: assert property (ld && sel && !readNotWrite ##1 !suspend_input
    |=> !dataOe)
    else $error("bus driven in write data cycle");
  chk_gate_floats: assert property (outputGate_n |-> !dataOe)
    else $error("bus driven with gate high");
  chk_word_held: assert property (suspend_input |=> $stable(dataOut))
    else $error("read word moved while suspended");
  chk_oe_held: assert property (suspend_input ##1 $stable(outputGate_n) |-> $stable(dataOe))
    else $error("drive changed on suspended edge");
  chk_write_taken: assert property (ld && sel && !readNotWrite ##1 !suspend_input |=> writeBusy)
    else $error("write data not taken");
  chk_write_waits: assert property (ld && sel && !readNotWrite ##1 suspend_input ##1 !suspend_input
    |=> writeBusy)
    else $error("write data not taken after suspend");
  chk_reset_idle: assert property ($fell(reset) |-> !dataOe && !writeBusy)
    else $error("bus not idle after reset");
endmodule
bind sss_sram_port sss_port_monitor mon_u (.*);
`default_nettype wire

// ---- testbench/sss_ctrl_model.sv ----
// Controller data-phase model: strobes and write data
`timescale 1ns/1ns
`default_nettype none
module sss_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        suspend_input,
  input  wire logic        readNotWrite,
  input  wire logic        select_low_a_n,
  input  wire logic        select_low_b_n,
  input  wire logic        select_high,
  input  wire logic [35:0] cmdData,
  output logic      [3:0]  byte_lane_write_n,
  output logic      [35:0] dataIn
);
  logic        wrPend_q;
  logic [35:0] wrData_q;
  logic [35:0] lastData_q;
  // strobes low with each write load
  assign byte_lane_write_n = readNotWrite ? cmdData[3:0] : 4'h0;
  // data rides beside the next load; idle bus shows the inverse
  assign dataIn = wrPend_q ? wrData_q : ~lastData_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPend_q <= 1'h0;
      wrData_q <= 36'h0;
      lastData_q <= 36'h0;
    end else if (!suspend_input) begin
      wrPend_q <= !readNotWrite && !select_low_a_n && !select_low_b_n && select_high;
      wrData_q <= cmdData;
      lastData_q <= dataIn;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/sync_sram_select_suspend_cycles_bench.sv ----
// Random traffic bench against a behavioural memory
`timescale 1ns/1ns
`default_nettype none
module sync_sram_select_suspend_cycles_bench;
  logic core_clk = 1'h0, reset = 1'h1, readNotWrite = 1'h1, suspend_input = 1'h0;
  logic select_low_a_n = 1'h1, select_low_b_n = 1'h1, select_high = 1'h0, outputGate_n = 1'h1;
  logic advance_or_load = 1'h0, burst_order_select_n = 1'h0, burst_order_select_oe = 1'h0;
  logic [16:0] address = 17'h0;
  logic [35:0] cmdData = 36'h0, dataIn, dataOut, expData;
  logic [3:0]  byte_lane_write_n;
  logic        dataOe, writeBusy, writeStall, sel;
  logic        expKnown = 1'h0, expOe = 1'h0, expBusy = 1'h0;
  logic        pendRd = 1'h0, pendWr = 1'h0, pendKnown = 1'h0;
  logic [35:0] pendData = 36'h0;
  logic [35:0] mem [int];
  logic [31:0] seed = 32'he2a75460;
  int          miscompares = 0, checked = 0;
  sss_ctrl_model ctrl_u (.*);
  sss_sram_port dut_u (.*);
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(string name, logic [35:0] exp, logic [35:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #10000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'h0;
    for (int i = 0; i < 600; i++) begin
      // Outputs are settled at the falling edge; inputs shown are for the next rise
      @(negedge core_clk);
      chk("dataOe", {35'h0, expOe && !outputGate_n}, {35'h0, dataOe});
      if (expOe && expKnown && !outputGate_n) chk("dataOut", expData, dataOut);
      chk("writeBusy", {35'h0, expBusy}, {35'h0, writeBusy});
      chk("writeStall", 36'h0, {35'h0, writeStall});
      sel = !select_low_a_n && !select_low_b_n && select_high;
      // Suspended edges leave the model untouched except expBusy, which clears; the data phase follows the load
      if (!suspend_input) begin
        expOe = pendRd;
        expKnown = pendKnown;
        expData = pendData;
        expBusy = pendWr;
        pendRd = readNotWrite && sel;
        pendWr = !readNotWrite && sel;
        pendKnown = mem.exists(address);
        pendData = pendKnown ? mem[address] : 36'h0;
        if (pendWr) mem[address] = cmdData;
      end else begin
        expBusy = 1'h0;
      end
      @(posedge core_clk);
      seed = xs(seed);
      // Reads and writes use opposite address parity, swapped after a quiet gap
      suspend_input <= i % 150 >= 4 && seed[1:0] == 2'h0;
      outputGate_n <= seed[4:2] == 3'h0;
      readNotWrite <= seed[5];
      {select_low_a_n, select_low_b_n, select_high} <=
        (i % 150 < 4) ? 3'h0 : (seed[6] ? 3'h1 : seed[9:7]);
      address <= {13'h0, seed[12:10], seed[5] == ((i / 150) % 2 == 1)};
      cmdData <= {seed[3:0], ~seed};
    end
    conclude();
  end
endmodule
`default_nettype wire
